// ===== shared/adcc_map.svh
// register offsets, field positions, reset values and sample lengths of the converter control
// assumes an AHB-Lite slave decoding the low address byte, one aligned word per register
// Function
// RULE_01 - resolution field selects 10-bit or 8-bit results
// RULE_02 - software mode: control write starts, unless channel all-ones
// RULE_03 - hardware mode: trigger event starts a conversion
// RULE_04 - continuous: restart right after result transfer
// RULE_05 - software continuous: start on write, repeat until abort
// RULE_06 - hardware continuous: start on trigger, repeat until abort
// RULE_07 - low-power bit selects low-power operation
// RULE_08 - divider field divides input clock, 00 by one
// RULE_09 - long sample bit selects long sample time
// RULE_10 - input clock field picks source, 00 bus clock
// RULE_11 - active flag reads one while converting
// RULE_12 - trigger select bit: zero software, one hardware
// RULE_13 - compare enable bit, zero means no compare
// RULE_14 - bits 3:2 read zero, software writes reserved zero
// RULE_15 - complete flag read-only, set when conversion finishes
// RULE_16 - interrupt enable raises request on complete flag
// RULE_17 - continuous bit: one repeats, zero single conversion
// RULE_18 - channel field selects analog input channel
// RULE_19 - high byte read first, pair kept coherent
// RULE_20 - compare value pair holds software compare value
// RULE_21 - pin control bit takes pin from port
// RULE_22 - software configures trigger register before channel register
// RULE_23 - rising trigger edge starts, ignored while converting
// RULE_24 - continuous hardware mode acts on first edge only
// RULE_25 - divider supports one, two, four or eight
// RULE_26 - analog pin: output off, pullup off, input off
// RULE_27 - control write aborts running conversion first
// RULE_28 - low byte read or control write clears flag
`ifndef ADCC_MAP_SVH
`define ADCC_MAP_SVH
`define ADCC_OFF_SC1     8'h00
`define ADCC_OFF_SC2     8'h04
`define ADCC_OFF_RH      8'h08
`define ADCC_OFF_RL      8'h0c
`define ADCC_OFF_CVH     8'h10
`define ADCC_OFF_CVL     8'h14
`define ADCC_OFF_CFG     8'h18
`define ADCC_OFF_PC1     8'h1c
`define ADCC_OFF_PC2     8'h20
`define ADCC_CFG_LP      7
`define ADCC_CFG_DIV     6:5
`define ADCC_CFG_LSMP    4
`define ADCC_CFG_MODE    3:2
`define ADCC_CFG_CLK     1:0
`define ADCC_SC1_CONVERSION_COMPLETE_FLAG    7
`define ADCC_SC1_COMPLETE_INTERRUPT_ENABLE    6
`define ADCC_SC1_CONT    5
`define ADCC_SC1_CH      4:0
`define ADCC_SC2_ACT     7
`define ADCC_SC2_TRG     6
`define ADCC_SC2_CFE     5
`define ADCC_SC2_CGT     4
`define ADCC_SC2_RSV     1:0
`define ADCC_CFG_RST     8'h00
`define ADCC_CH_OFF      5'h1f
`define ADCC_MODE_10     2'h2
`define ADCC_SAMPLE_SHORT 5'h04
`define ADCC_SAMPLE_LONG  5'h18
`endif

// ===== shared/adcc_pkg.sv
// state types of the converter control modules
// assumes the map header supplies all numbers
package adcc_pkg;
  typedef enum logic [1:0] {ADCC_S_IDLE, ADCC_S_SAMPLE, ADCC_S_CONVERT} adcc_sar_state_type;
  typedef struct packed {
    logic [2:0] cnt;
    logic       half;
    logic       tick;
  } adcc_div_state_type;
  typedef struct packed {
    adcc_sar_state_type state;
    logic [4:0]         cnt;
    logic [3:0]         bitpos;
    logic [9:0]         code;
    logic               busy;
    logic               sampling;
    logic               done;
    logic [9:0]         result;
  } adcc_sar_state_type_s_type;
  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [7:0]  cfg;
    logic        trg;
    logic        compare_enable;
    logic        compare_greater_select;
    logic [1:0]  rsv;
    logic        conversion_complete_flag;
    logic        complete_interrupt_enable;
    logic        continuous_select;
    logic [4:0]  channel_select;
    logic [9:0]  res;
    logic [9:0]  cv;
    logic [15:0] pins;
    logic        lock;
    logic        pend;
    logic [9:0]  pend_res;
    logic        running;
    logic        trig_prev;
    logic        start;
    logic        abort;
    logic        irq;
  } adcc_top_state_type;
endpackage : adcc_pkg

// ===== hw/adcc_clkdiv.sv
// conversion clock enable: source pick and divide by 1, 2, 4 or 8
// assumes alt_tick is a one-cycle enable already in the system clock domain
`timescale 1ns/1ps
`include "adcc_map.svh"
module adcc_clkdiv (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] sel,
  input  wire logic [1:0] div,
  input  wire logic       alt_tick,
  output logic            tick
);
  adcc_pkg::adcc_div_state_type st;
  adcc_pkg::adcc_div_state_type next_st;
  logic       src;
  logic [2:0] mask;

  // source enable then power-of-two divide
  always_comb begin
    next_st      = st;
    next_st.tick = 1'b0;
    next_st.half = ~st.half;
    case (sel)                                       // [RULE_10]
      2'h0:    src = 1'b1;
      2'h1:    src = st.half;
      default: src = alt_tick;
    endcase
    case (div)                                       // [RULE_08] [RULE_25]
      2'h0:    mask = 3'h0;
      2'h1:    mask = 3'h1;
      2'h2:    mask = 3'h3;
      default: mask = 3'h7;
    endcase
    if (src) begin
      if (st.cnt >= mask) begin
        next_st.cnt  = 3'h0;
        next_st.tick = 1'b1;
      end else begin
        next_st.cnt = st.cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) st <= '0;
    else st <= next_st;
  end
  assign tick = st.tick;

  // bus clock divided by eight gives one tick in eight cycles
  div_eight_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_25]
    (tick && sel == 2'h0 && div == 2'h3) ##1 (sel == 2'h0 && div == 2'h3 && !tick) [*7] ##1
    (sel == 2'h0 && div == 2'h3) |-> tick)
    else $error("divide by eight period wrong");
endmodule : adcc_clkdiv

// ===== hw/adcc_sar.sv
// successive approximation sequencer: sample phase, then one bit per conversion tick
// assumes comp_high is the comparator answer to dac_code, valid at each tick
`timescale 1ns/1ps
`include "adcc_map.svh"
module adcc_sar (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       tick,
  input  wire logic       start,
  input  wire logic       abort,
  input  wire logic       long_sample,
  input  wire logic       ten_bit,
  input  wire logic       comp_high,
  output logic            busy,
  output logic            sampling,
  output logic [9:0]      dac_code,
  output logic            done,
  output logic [9:0]      result
);
  adcc_pkg::adcc_sar_state_type_s_type st;
  adcc_pkg::adcc_sar_state_type_s_type next_st;
  logic [9:0] trial;

  // sequencer; start restarts even a running conversion
  always_comb begin
    next_st      = st;
    next_st.done = 1'b0;
    trial        = st.code;
    case (st.state)
      adcc_pkg::ADCC_S_SAMPLE: begin
        if (tick) begin
          if (st.cnt == 5'h00) begin
            next_st.state    = adcc_pkg::ADCC_S_CONVERT;
            next_st.sampling = 1'b0;
            next_st.code     = ten_bit ? 10'h200 : 10'h080;          // [RULE_01]
            next_st.bitpos   = ten_bit ? 4'h9 : 4'h7;
          end else begin
            next_st.cnt = st.cnt - 5'h01;
          end
        end
      end
      adcc_pkg::ADCC_S_CONVERT: begin
        if (tick) begin
          if (!comp_high) trial[st.bitpos] = 1'b0;
          if (st.bitpos == 4'h0) begin
            next_st.state  = adcc_pkg::ADCC_S_IDLE;
            next_st.busy   = 1'b0;
            next_st.done   = 1'b1;
            next_st.result = trial;
          end else begin
            trial[st.bitpos - 4'h1] = 1'b1;
            next_st.bitpos = st.bitpos - 4'h1;
          end
          next_st.code = trial;
        end
      end
      default: ;
    endcase
    if (abort) begin                                                  // [RULE_27]
      next_st.state    = adcc_pkg::ADCC_S_IDLE;
      next_st.busy     = 1'b0;
      next_st.sampling = 1'b0;
      next_st.done     = 1'b0;
    end
    if (start) begin
      next_st.state    = adcc_pkg::ADCC_S_SAMPLE;
      next_st.cnt      = long_sample ? `ADCC_SAMPLE_LONG : `ADCC_SAMPLE_SHORT; // [RULE_09]
      next_st.busy     = 1'b1;
      next_st.sampling = 1'b1;
      next_st.done     = 1'b0;
      next_st.code     = 10'h000;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) st <= '0;
    else st <= next_st;
  end
  assign busy     = st.busy;
  assign sampling = st.sampling;
  assign dac_code = st.code;
  assign done     = st.done;
  assign result   = st.result;

  eight_bit_res_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_01]
    (st.state == adcc_pkg::ADCC_S_CONVERT && tick && st.bitpos == 4'h0 && !ten_bit
     && !start && !abort && st.code[9:8] == 2'h0) |=> done && result[9:8] == 2'h0)
    else $error("eight bit result has high bits set");
endmodule : adcc_sar

// ===== hw/adcc_top.sv
// converter control: AHB-Lite register file, trigger logic, result transfer and compare
// assumes one 25 MHz clock, zero-wait word accesses, synchronous trigger and comparator inputs
`timescale 1ns/1ps
`include "adcc_map.svh"
module adcc_top (
  input  wire logic        SYS_CLK,
  input  wire logic        RESETN,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic        HW_TRIGGER,
  input  wire logic        ALT_CLK_TICK,
  input  wire logic        COMP_HIGH,
  output logic      [9:0]  DAC_CODE,
  output logic             SAMPLE_ACTIVE,
  output logic      [4:0]  CONV_CHANNEL,
  output logic             LOW_POWER_MODE,
  output logic      [15:0] ANALOG_PIN_SELECT,
  output logic             CONV_IRQ
);
  adcc_pkg::adcc_top_state_type st;
  adcc_pkg::adcc_top_state_type next_st;

  logic       conv_tick;
  logic       sar_busy;
  logic       sar_done;
  logic [9:0] sar_result;
  logic       addr_ok;
  logic [7:0] addr;
  logic       trig_edge;
  logic       wrote_sc1;
  logic       pass;

  // compare test; a disabled compare always passes
  function automatic logic cmp_pass(input logic [9:0] r, input logic [9:0] c,
                                    input logic en, input logic gt);
    if (!en) cmp_pass = 1'b1;                                         // [RULE_13]
    else if (gt) cmp_pass = (r >= c);
    else cmp_pass = (r < c);
  endfunction : cmp_pass

  // read view of every register, narrow data in the low bits
  function automatic logic [31:0] read_reg(input logic [7:0] a,
                                           input adcc_pkg::adcc_top_state_type s);
    case (a)
      `ADCC_OFF_SC1: read_reg = {24'h0, s.conversion_complete_flag, s.complete_interrupt_enable, s.continuous_select, s.channel_select};
      `ADCC_OFF_SC2: read_reg = {24'h0, s.running, s.trg, s.compare_enable, s.compare_greater_select,
                                 2'h0, s.rsv};                        // [RULE_11] [RULE_14]
      `ADCC_OFF_RH:  read_reg = {30'h0, s.res[9:8]};
      `ADCC_OFF_RL:  read_reg = {24'h0, s.res[7:0]};
      `ADCC_OFF_CVH: read_reg = {30'h0, s.cv[9:8]};
      `ADCC_OFF_CVL: read_reg = {24'h0, s.cv[7:0]};
      `ADCC_OFF_CFG: read_reg = {24'h0, s.cfg};
      `ADCC_OFF_PC1: read_reg = {24'h0, s.pins[7:0]};
      `ADCC_OFF_PC2: read_reg = {24'h0, s.pins[15:8]};
      default:       read_reg = 32'h0;
    endcase
  endfunction : read_reg

  adcc_clkdiv u_div (
    .clk      (SYS_CLK),
    .rst_n    (RESETN),
    .sel      (st.cfg[`ADCC_CFG_CLK]),
    .div      (st.cfg[`ADCC_CFG_DIV]),
    .alt_tick (ALT_CLK_TICK),
    .tick     (conv_tick)
  );

  adcc_sar u_sar (
    .clk         (SYS_CLK),
    .rst_n       (RESETN),
    .tick        (conv_tick),
    .start       (st.start),
    .abort       (st.abort),
    .long_sample (st.cfg[`ADCC_CFG_LSMP]),
    .ten_bit     (st.cfg[`ADCC_CFG_MODE] == `ADCC_MODE_10),
    .comp_high   (COMP_HIGH),
    .busy        (sar_busy),
    .sampling    (SAMPLE_ACTIVE),
    .dac_code    (DAC_CODE),
    .done        (sar_done),
    .result      (sar_result)
  );

  assign addr      = HADDR[7:0];
  assign addr_ok   = HSEL && HTRANS[1] && HREADY;
  assign trig_edge = HW_TRIGGER && !st.trig_prev;
  assign pass      = cmp_pass(sar_result, st.cv, st.compare_enable, st.compare_greater_select);

  // bus, trigger and completion handling; completion is applied after bus clears
  // so a flag set in the same cycle as its clear survives
  always_comb begin
    next_st           = st;
    next_st.start     = 1'b0;
    next_st.abort     = 1'b0;
    next_st.hreadyout = 1'b1;
    next_st.trig_prev = HW_TRIGGER;
    next_st.wr_pend   = addr_ok && HWRITE;
    wrote_sc1         = 1'b0;
    if (addr_ok) next_st.wr_addr = addr;
    // read side effects happen when the address phase is taken
    if (addr_ok && !HWRITE) begin
      next_st.hrdata = read_reg(addr, st);
      if (addr == `ADCC_OFF_RH) next_st.lock = 1'b1;                 // [RULE_19]
      if (addr == `ADCC_OFF_RL) begin
        next_st.lock = 1'b0;
        next_st.conversion_complete_flag = 1'b0;                                          // [RULE_28]
      end
    end
    // write data phase
    if (st.wr_pend) begin
      case (st.wr_addr)
        `ADCC_OFF_CFG: next_st.cfg = HWDATA[7:0];                     // [RULE_07] [RULE_09]
        `ADCC_OFF_SC2: begin
          next_st.trg   = HWDATA[`ADCC_SC2_TRG];                      // [RULE_12]
          next_st.compare_enable  = HWDATA[`ADCC_SC2_CFE];
          next_st.compare_greater_select = HWDATA[`ADCC_SC2_CGT];
          next_st.rsv   = HWDATA[`ADCC_SC2_RSV];
        end
        `ADCC_OFF_SC1: begin
          wrote_sc1       = 1'b1;
          next_st.complete_interrupt_enable    = HWDATA[`ADCC_SC1_COMPLETE_INTERRUPT_ENABLE];                   // [RULE_16]
          next_st.continuous_select    = HWDATA[`ADCC_SC1_CONT];                   // [RULE_17]
          next_st.channel_select    = HWDATA[`ADCC_SC1_CH];                     // [RULE_18]
          next_st.conversion_complete_flag    = 1'b0;                                     // [RULE_28]
          next_st.pend    = 1'b0;
          next_st.abort   = 1'b1;                                     // [RULE_27]
          next_st.running = 1'b0;
          if (HWDATA[`ADCC_SC1_CH] != `ADCC_CH_OFF && !st.trg) begin
            next_st.start   = 1'b1;                                   // [RULE_02] [RULE_05]
            next_st.running = 1'b1;
          end
        end
        `ADCC_OFF_CVH: next_st.cv[9:8] = HWDATA[1:0];                 // [RULE_20]
        `ADCC_OFF_CVL: next_st.cv[7:0] = HWDATA[7:0];
        `ADCC_OFF_PC1: next_st.pins[7:0] = HWDATA[7:0];               // [RULE_21]
        `ADCC_OFF_PC2: next_st.pins[15:8] = HWDATA[7:0];
        default: ;
      endcase
    end
    // conversion finished: transfer on a compare pass, unless high byte has been read
    if (sar_done) begin
      if (pass && st.lock && next_st.lock) begin
        next_st.pend     = 1'b1;                                      // [RULE_19]
        next_st.pend_res = sar_result;
        // a held single result means nothing is converting any more
        if (!st.continuous_select && !wrote_sc1) next_st.running = 1'b0;          // [RULE_11]
      end else begin
        if (pass) begin
          next_st.res  = sar_result;
          next_st.conversion_complete_flag = 1'b1;                                        // [RULE_15]
        end
        if (st.continuous_select && !wrote_sc1) next_st.start = 1'b1;              // [RULE_04]
        else if (!wrote_sc1) next_st.running = 1'b0;
      end
    end else if (st.pend && !next_st.lock) begin
      // held result moves in once the low byte has been read
      next_st.pend = 1'b0;
      next_st.res  = st.pend_res;
      next_st.conversion_complete_flag = 1'b1;
      if (st.continuous_select && st.running) next_st.start = 1'b1;
      else next_st.running = 1'b0;
    end
    // edges while running are dropped, which also keeps continuous runs on their
    // first edge only
    if (st.trg && trig_edge && !st.running && !st.wr_pend
        && st.channel_select != `ADCC_CH_OFF) begin                             // [RULE_03] [RULE_23]
      next_st.start   = 1'b1;                                         // [RULE_06] [RULE_24]
      next_st.running = 1'b1;
    end
    next_st.irq = next_st.conversion_complete_flag && next_st.complete_interrupt_enable;                       // [RULE_16]
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      st           <= '0;
      st.hreadyout <= 1'b1;
      st.channel_select      <= `ADCC_CH_OFF;
      st.cfg       <= `ADCC_CFG_RST;
    end else begin
      st <= next_st;
    end
  end

  // every output but HRESP straight from state flops; response is always okay
  assign HRDATA            = st.hrdata;
  assign HREADYOUT         = st.hreadyout;
  assign HRESP             = 1'b0;
  assign CONV_CHANNEL      = st.channel_select;
  assign LOW_POWER_MODE    = st.cfg[`ADCC_CFG_LP];                    // [RULE_07]
  assign ANALOG_PIN_SELECT = st.pins;                                 // [RULE_21] [RULE_26]
  assign CONV_IRQ          = st.irq;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);

  sw_start_a: assert property (st.start |=> sar_busy ##0 SAMPLE_ACTIVE)  // [RULE_02]
    else $error("start did not launch a conversion");
  ch_off_a: assert property ((st.wr_pend && st.wr_addr == `ADCC_OFF_SC1 // [RULE_02]
    && HWDATA[4:0] == 5'h1f && !sar_done) |=> !st.start ##1 !sar_busy)
    else $error("all-ones channel started a conversion");
  sw_ignores_hw_a: assert property ((!st.trg && trig_edge && !st.wr_pend // [RULE_12]
    && !sar_done && !st.pend) |=> !st.start)
    else $error("trigger edge acted on in software mode");
  busy_edge_a: assert property ((st.running && trig_edge && !sar_done // [RULE_23]
    && !st.wr_pend && !st.pend) |=> !st.start)
    else $error("trigger edge accepted during conversion");
  // an abort lets the sequencer stay busy one cycle after the flag drops
  active_flag_a: assert property ((sar_busy && !st.abort) |-> st.running) // [RULE_11]
    else $error("active flag low while converting");
  cont_restart_a: assert property ((sar_done && st.continuous_select && !st.lock && !st.wr_pend) // [RULE_04]
    |=> st.start ##1 sar_busy)
    else $error("continuous mode did not restart");
  single_stop_a: assert property ((sar_done && !st.continuous_select && !st.wr_pend) // [RULE_17]
    |=> !st.start && !st.running)
    else $error("single mode restarted");
  // a low-byte read in the same cycle completes the pair, so the new result may land
  coherent_hold_a: assert property ((st.lock && sar_done // [RULE_19]
    && !(addr_ok && !HWRITE && addr == `ADCC_OFF_RL)) |=> st.res == $past(st.res))
    else $error("result overwritten between byte reads");
  irq_follow_a: assert property ((sar_done && st.complete_interrupt_enable && !st.compare_enable && !st.lock // [RULE_16]
    && !st.wr_pend) |=> st.conversion_complete_flag && CONV_IRQ)
    else $error("complete flag did not raise request");
  rsv_read_a: assert property ((addr_ok && !HWRITE && addr == `ADCC_OFF_SC2) // [RULE_14]
    |=> HRDATA[3:2] == 2'h0 && HREADYOUT)
    else $error("reserved bits read nonzero");

  single_done_c: cover property (st.start ##[1:600] sar_done ##1 CONV_IRQ);
  cont_run_c: cover property (sar_done && st.continuous_select ##1 st.start);
  hw_start_c: cover property (st.trg && trig_edge ##1 st.start);
  cmp_fail_c: cover property (sar_done && st.compare_enable && !pass);
endmodule : adcc_top

// ===== tb/adcc_analog_src.sv
// partner model: analog input level against the trial code, plus the trigger source
// assumes the bench sets the level and pulses fire for one cycle
`timescale 1ns/1ps
module adcc_analog_src (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [9:0] dac_code,
  input  wire logic [9:0] level,
  input  wire logic       fire,
  output logic            comp_high,
  output logic            trig
);
  logic [1:0] hold;
  // ideal comparator, no noise, so the code settles exactly on the level
  assign comp_high = (level >= dac_code);
  // trigger held three cycles so no sampling slip can miss it; low between events
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold <= 2'h0;
    end else if (fire) begin
      hold <= 2'h3;
    end else if (hold != 2'h0) begin
      hold <= hold - 2'h1;
    end
  end
  assign trig = (hold != 2'h0);
endmodule : adcc_analog_src

// ===== tb/adcc_tb_top.sv
// self-checking bench of the converter control: bus tasks, read queue, scenarios
// assumes a zero-wait AHB-Lite slave and the partner model as analog source
`timescale 1ns/1ps
`include "adcc_map.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD %0t got %h want %h", $time, (g), (e)); end end
module adcc_tb_top;
  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        fire = 1'b0;
  logic [9:0]  level = 10'h0;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, comp_high, trig, low_power, irq, sampling;
  logic [9:0]  dac_code;
  logic [4:0]  channel;
  logic [15:0] pin_sel;
  logic [31:0] exp_q[$];
  logic        rd_ph = 1'b0;
  integer      seed = 32'h1cd8;
  integer      bad_count = 0;
  integer      checked = 0;
  integer      n, i;
  integer      dur[5];
  logic [9:0]  lv;
  logic [7:0]  pc2;

  adcc_top u_adcc_top (
    .SYS_CLK(sys_clk), .RESETN(resetn), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .HW_TRIGGER(trig), .ALT_CLK_TICK(1'b0),
    .COMP_HIGH(comp_high), .DAC_CODE(dac_code), .SAMPLE_ACTIVE(sampling),
    .CONV_CHANNEL(channel), .LOW_POWER_MODE(low_power), .ANALOG_PIN_SELECT(pin_sel),
    .CONV_IRQ(irq));
  adcc_analog_src u_adcc_analog_src (
    .clk(sys_clk), .rst_n(resetn), .dac_code(dac_code), .level(level), .fire(fire),
    .comp_high(comp_high), .trig(trig));

  always #20 sys_clk = ~sys_clk;

  // read data compared at the edge ending its data phase, oldest note first
  always @(posedge sys_clk) begin
    if (rd_ph && hreadyout) begin
      `CHK(hrdata, exp_q.pop_front())
      `CHK(hresp, 1'b0)
    end
    rd_ph <= hsel && htrans[1] && hreadyout && !hwrite;
  end

  // one single word transfer; for a read d is the expected word
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    if (w) begin
      hwdata <= d;
    end else begin
      exp_q.push_back(d);
    end
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
  endtask : xfer

  // sampled on the falling edge so the register update has landed
  task automatic wait_irq();
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(negedge sys_clk);
      n++;
    end
    `CHK(irq, 1'b1)
    @(posedge sys_clk);
  endtask : wait_irq

  task automatic close_out();
    if (bad_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  // whole run is under a thousand cycles, so this only fires on a hang
  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    close_out();
  end

  initial begin
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    // reset values and an unmapped word
    xfer(0, `ADCC_OFF_SC1, 32'h1f);
    xfer(0, `ADCC_OFF_SC2, 32'h0);
    xfer(0, `ADCC_OFF_CFG, 32'h0);
    xfer(0, 8'h40, 32'h0);
    // low power, 10-bit, undivided bus clock; pin 1 made analog
    pc2 = 8'($random(seed));
    xfer(1, `ADCC_OFF_CFG, 32'h88);
    xfer(1, `ADCC_OFF_PC1, 32'h02);
    xfer(1, `ADCC_OFF_PC2, {24'h0, pc2});
    xfer(0, `ADCC_OFF_CFG, 32'h88);
    @(negedge sys_clk);
    `CHK(low_power, 1'b1)
    `CHK(pin_sel, {pc2, 8'h02})
    @(posedge sys_clk);
    // trigger register first, reserved low bits kept zero
    xfer(1, `ADCC_OFF_SC2, 32'h2c);
    xfer(0, `ADCC_OFF_SC2, 32'h20);
    xfer(1, `ADCC_OFF_SC2, 32'h00);
    // single software conversion with interrupt
    lv = 10'($random(seed));
    level <= lv;
    xfer(1, `ADCC_OFF_SC1, 32'h41);
    xfer(0, `ADCC_OFF_SC2, 32'h80);
    `CHK(channel, 5'h01)
    `CHK(sampling, 1'b1)
    wait_irq();
    xfer(0, `ADCC_OFF_SC1, 32'hc1);
    xfer(0, `ADCC_OFF_RH, {30'h0, lv[9:8]});
    xfer(0, `ADCC_OFF_RL, {24'h0, lv[7:0]});
    xfer(0, `ADCC_OFF_SC1, 32'h41);
    // continuous: the locked pair survives the next conversion, whose result is held
    lv = 10'($random(seed));
    level <= lv;
    xfer(1, `ADCC_OFF_SC1, 32'h61);
    wait_irq();
    level <= ~lv;
    xfer(0, `ADCC_OFF_RH, {30'h0, lv[9:8]});
    repeat (80) @(posedge sys_clk);
    xfer(0, `ADCC_OFF_RL, {24'h0, lv[7:0]});
    xfer(0, `ADCC_OFF_RH, {30'h0, ~lv[9:8]});
    xfer(0, `ADCC_OFF_RL, {24'h0, ~lv[7:0]});
    xfer(1, `ADCC_OFF_SC1, 32'h1f);
    xfer(0, `ADCC_OFF_SC2, 32'h0);
    xfer(0, `ADCC_OFF_SC1, 32'h1f);
    // hardware trigger: a write only arms, an edge while busy is dropped
    lv = 10'($random(seed));
    level <= lv;
    xfer(1, `ADCC_OFF_SC2, 32'h40);
    xfer(1, `ADCC_OFF_SC1, 32'h41);
    xfer(0, `ADCC_OFF_SC2, 32'h40);
    for (i = 0; i < 2; i++) begin
      fire <= 1'b1;
      @(posedge sys_clk);
      fire <= 1'b0;
      repeat (8) @(posedge sys_clk);
    end
    wait_irq();
    xfer(0, `ADCC_OFF_RL, {24'h0, lv[7:0]});
    repeat (40) @(posedge sys_clk);
    xfer(0, `ADCC_OFF_SC1, 32'h41);
    // hardware continuous: one edge launches, conversions then repeat alone
    xfer(1, `ADCC_OFF_SC1, 32'h61);
    fire <= 1'b1;
    @(posedge sys_clk);
    fire <= 1'b0;
    wait_irq();
    xfer(0, `ADCC_OFF_RL, {24'h0, lv[7:0]});
    wait_irq();
    xfer(1, `ADCC_OFF_SC1, 32'h1f);
    // each divider step and the long sample lengthen the conversion
    xfer(1, `ADCC_OFF_SC2, 32'h00);
    for (i = 0; i < 5; i++) begin
      xfer(1, `ADCC_OFF_CFG, (i < 4) ? (32'h08 | (i << 5)) : 32'h18);
      xfer(1, `ADCC_OFF_SC1, 32'h41);
      wait_irq();
      dur[i] = n;
      xfer(0, `ADCC_OFF_RL, {24'h0, lv[7:0]});
      if (i > 0) begin
        `CHK(dur[i] > dur[(i < 4) ? i - 1 : 0], 1'b1)
      end
    end
    // 8-bit mode on an in-range level, high byte reads zero
    level <= lv & 10'h0ff;
    xfer(1, `ADCC_OFF_CFG, 32'h00);
    xfer(1, `ADCC_OFF_SC1, 32'h41);
    wait_irq();
    `CHK(low_power, 1'b0)
    xfer(0, `ADCC_OFF_RH, 32'h0);
    xfer(0, `ADCC_OFF_RL, {24'h0, lv[7:0]});
    close_out();
  end
endmodule : adcc_tb_top
